// >>> cab_pin_model.sv
// far-side model: external count pin and the five channel pin levels
// assumes the bench resolves each channel wire from this level and drive
`timescale 1ns/10ps
module cab_pin_model (
    input  wire logic       CLK_IN,  // oscillator clock
    output logic            EXT_OUT, // external_count_input level
    output logic      [4:0] LVL_OUT  // levels put on channel pins
);
    initial
    begin
        EXT_OUT = 1'b1;
        LVL_OUT = 5'h1F;
    end

    // ten clocks a period keeps well under the /8 limit
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            repeat (5) @(posedge CLK_IN);
            EXT_OUT <= 1'b0;
            repeat (5) @(posedge CLK_IN);
            EXT_OUT <= 1'b1;
        end
    endtask : ext_pulses

    task automatic pin_set(input int ch, input logic v);
        @(posedge CLK_IN);
        LVL_OUT[ch] <= v;
    endtask : pin_set
endmodule : cab_pin_model

// >>> cab_pkg.sv
// counter array time base: register map, field positions, reset values
// assumes one 200 MHz clock that also serves as the oscillator time base
package cab_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int ADDR_W  = 6;
    localparam int DATA_W  = 8;
    localparam int CNT_W   = 16;
    localparam int NUM_MOD = 5;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [5:0] MODE_OFS  = 6'h00; // counter_mode_reg
    localparam logic [5:0] CTRL_OFS  = 6'h01; // counter_control_reg
    localparam logic [5:0] CNTL_OFS  = 6'h02; // count_low_byte
    localparam logic [5:0] CNTH_OFS  = 6'h03; // count_high_byte
    localparam logic [5:0] IST_OFS   = 6'h04; // irq status, read only
    localparam logic [5:0] ICLR_OFS  = 6'h05; // irq clear, write only
    localparam logic [5:0] IEN_OFS   = 6'h06; // irq enable
    localparam logic [2:0] MMODE_GRP = 3'h1;  // 08..0C module modes
    localparam logic [2:0] CAPL_GRP  = 3'h2;  // 10..14 module low bytes
    localparam logic [2:0] CAPH_GRP  = 3'h3;  // 18..1C module high bytes

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MODE_IRQ_BIT  = 0;
    localparam int MODE_SRC_LSB  = 1;
    localparam int MODE_WDT_BIT  = 6;
    localparam int MODE_IDLE_BIT = 7;
    localparam int CTRL_OVF_BIT  = 7;
    localparam int CTRL_RUN_BIT  = 6;
    localparam int WDT_MOD       = 4;

    // ************************************************************
    // reset values and timing counts
    // ************************************************************
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  IEN_RST    = 8'h9F;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [7:0]  LOW_MAX    = 8'hFF;
    localparam logic [3:0]  DIV12_LAST = 4'hB;
    localparam logic [3:0]  DIV6_LAST  = 4'h5;

    typedef enum logic [1:0] {
        SRC_SLOW = 2'h0,
        SRC_FAST = 2'h1,
        SRC_T0   = 2'h2,
        SRC_EXT  = 2'h3
    } cab_src_t;

    typedef struct packed {
        logic ecom;
        logic capp;
        logic capn;
        logic mat;
        logic tog;
        logic pwm;
        logic eccf;
    } cab_mmode_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cab_bus_t;

endpackage : cab_pkg

// >>> cab_timebase.sv
// counter array time base with five compare/capture channels
// assumes a single-cycle register port and a same-clock timer 0 pulse;
// external count and channel pins are asynchronous
`timescale 1ns/10ps

// Overview of operation
// - sixteen-bit counter, both bytes software read/write
// - one counter shared by all five channels
// - codes 00/01 pick divided oscillator rates
// - code 10 timer 0 overflow, 11 external
// - timer 0 overflow counts regardless of interrupt
// - mode bits 2:1 source, bit 0 enable
// - run bit 6 starts and stops counting
// - overflow sets bit 7, interrupts when enabled
// - only software clears the overflow flag
// - each channel owns a software-cleared event flag
// - channels 0..4 on port 1 bits 3..7
// - capture, timer, fast output, pwm; watchdog ch4
// - unused channel leaves its pin released
module cab_timebase (
    input  wire logic       CLK_IN,          // oscillator clock
    input  wire logic       NRST_IN,         // sync reset, low active
    input  wire logic [5:0] ADDR_IN,         // register address
    input  wire logic [7:0] WDATA_IN,        // write data
    input  wire logic       WR_IN,           // write strobe
    input  wire logic       RD_IN,           // read strobe
    output logic      [7:0] RDATA_OUT,       // read data, next cycle
    input  wire logic       SIX_CLK_MODE_IN, // 1 = six-clock mode
    input  wire logic       IDLE_IN,         // processor in idle
    input  wire logic       T0_OVF_IN,       // timer 0 overflow pulse
    input  wire logic       EXT_COUNT_IN,    // external_count_input pin
    input  wire logic [4:0] MOD_PIN_IN,      // channel pin levels
    output logic      [4:0] MOD_PIN_OUT,     // channel pin drive
    output logic      [4:0] MOD_PIN_OE_N_OUT,// low = channel drives pin
    output logic            IRQ_OUT,         // level interrupt
    output logic            WDT_RESET_OUT    // watchdog reset pulse
);

    // ************************************************************
    // register port decode
    // ************************************************************
    cab_pkg::cab_bus_t bus;
    logic wr_mode, wr_ctrl, wr_cntl, wr_cnth, wr_iclr, wr_ien;
    logic [2:0] grp;
    logic [2:0] idx;
    logic       idx_ok;

    assign bus     = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
    assign wr_mode = bus.wr && (bus.addr == cab_pkg::MODE_OFS);
    assign wr_ctrl = bus.wr && (bus.addr == cab_pkg::CTRL_OFS);
    assign wr_cntl = bus.wr && (bus.addr == cab_pkg::CNTL_OFS);
    assign wr_cnth = bus.wr && (bus.addr == cab_pkg::CNTH_OFS);
    assign wr_iclr = bus.wr && (bus.addr == cab_pkg::ICLR_OFS);
    assign wr_ien  = bus.wr && (bus.addr == cab_pkg::IEN_OFS);
    assign grp     = bus.addr[5:3];
    assign idx     = bus.addr[2:0];
    assign idx_ok  = (idx < 3'h5);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]          mode_q;
    logic                run_q;
    logic                ovf_flag_q;
    logic [4:0]          ev_flag_q;
    logic [7:0]          ien_q;
    logic [15:0]         cnt_q;
    logic [3:0]          div_q;
    logic                adv_q;
    logic                eci_s1_q, eci_s2_q, eci_s3_q;
    logic [4:0]          pin_s1_q, pin_s2_q, pin_s3_q;
    cab_pkg::cab_mmode_t mmode_q [5];
    logic [15:0]         cap_q   [5];
    logic [4:0]          cap_ev, match_ev, ev;

    cab_pkg::cab_src_t src;
    logic div_last_hit, pulse_slow, pulse_fast, eci_fall;
    logic cnt_pulse, idle_stop, tick, ovf, cnt_wr;
    logic [3:0] div_last;

    assign src       = cab_pkg::cab_src_t'(mode_q[cab_pkg::MODE_SRC_LSB +: 2]);
    assign idle_stop = IDLE_IN && mode_q[cab_pkg::MODE_IDLE_BIT];
    assign cnt_wr    = wr_cntl || wr_cnth;

    // ************************************************************
    // synchronisers for asynchronous pins
    // ************************************************************
    // only the second and third stages feed edge logic; the first is metastable
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            eci_s1_q <= 1'b1;
            eci_s2_q <= 1'b1;
            eci_s3_q <= 1'b1;
        end
        else
        begin
            eci_s1_q <= EXT_COUNT_IN;
            eci_s2_q <= eci_s1_q;
            eci_s3_q <= eci_s2_q;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            pin_s1_q <= 5'h1F;
            pin_s2_q <= 5'h1F;
            pin_s3_q <= 5'h1F;
        end
        else
        begin
            pin_s1_q <= MOD_PIN_IN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign eci_fall = eci_s3_q && !eci_s2_q;

    // ************************************************************
    // oscillator prescaler
    // ************************************************************
    assign div_last     = SIX_CLK_MODE_IN ? cab_pkg::DIV6_LAST
                                          : cab_pkg::DIV12_LAST;
    assign div_last_hit = (div_q >= div_last);

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            div_q <= 4'h0;
        else if (div_last_hit)
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    end

    // one divider serves both rates: 12 and 6 are multiples of 4 and 2
    assign pulse_slow = (div_q == div_last);
    assign pulse_fast = SIX_CLK_MODE_IN ? div_q[0]
                                        : (div_q[1:0] == 2'h3);

    always_comb
    begin
        case (src)
            cab_pkg::SRC_SLOW: cnt_pulse = pulse_slow;
            cab_pkg::SRC_FAST: cnt_pulse = pulse_fast;
            cab_pkg::SRC_T0:   cnt_pulse = T0_OVF_IN;
            cab_pkg::SRC_EXT:  cnt_pulse = eci_fall;
            default:           cnt_pulse = 1'b0;
        endcase
    end

    assign tick = run_q && cnt_pulse && !idle_stop;
    assign ovf  = tick && !cnt_wr && (cnt_q == cab_pkg::CNT_MAX);

    // ************************************************************
    // counter and configuration
    // ************************************************************
    // a byte write in the same cycle as a pulse takes priority
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            cnt_q <= cab_pkg::CNT_RST;
        else if (wr_cntl)
            cnt_q[7:0] <= bus.wdata;
        else if (wr_cnth)
            cnt_q[15:8] <= bus.wdata;
        else if (tick)
            cnt_q <= cnt_q + 16'h0001;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            adv_q <= 1'b0;
        else
            adv_q <= tick && !cnt_wr;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            mode_q <= cab_pkg::MODE_RST;
        else if (wr_mode)
            mode_q <= bus.wdata;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            ien_q <= cab_pkg::IEN_RST;
        else if (wr_ien)
            ien_q <= bus.wdata;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            run_q <= 1'b0;
        else if (wr_ctrl)
            run_q <= bus.wdata[cab_pkg::CTRL_RUN_BIT];
    end

    // ************************************************************
    // event flags: clear by writing zero to control or one to clear
    // ************************************************************
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            ovf_flag_q <= 1'b0;
        else if (ovf)
            ovf_flag_q <= 1'b1;
        else if ((wr_ctrl && !bus.wdata[cab_pkg::CTRL_OVF_BIT]) ||
                 (wr_iclr && bus.wdata[cab_pkg::CTRL_OVF_BIT]))
            ovf_flag_q <= 1'b0;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            ev_flag_q <= 5'h00;
        else
            ev_flag_q <= (ev_flag_q
                          & (wr_ctrl ? bus.wdata[4:0] : 5'h1F)
                          & ~(wr_iclr ? bus.wdata[4:0] : 5'h00))
                         | ev;
    end

    // ************************************************************
    // compare/capture channels; index n drives port 1 bit n+3
    // ************************************************************
    for (genvar i = 0; i < cab_pkg::NUM_MOD; i++)
    begin : g_mod
        cab_pkg::cab_mmode_t m;
        logic rise, fall;
        assign m    = mmode_q[i];
        assign rise = pin_s2_q[i] && !pin_s3_q[i];
        assign fall = !pin_s2_q[i] && pin_s3_q[i];
        assign cap_ev[i]   = (m.capp && rise) || (m.capn && fall);
        assign match_ev[i] = m.ecom && m.mat && adv_q &&
                             (cnt_q == cap_q[i]);
        assign ev[i]       = cap_ev[i] || match_ev[i];

        always_ff @(posedge CLK_IN)
        begin
            if (!NRST_IN)
                mmode_q[i] <= '0;
            else if (bus.wr && grp == cab_pkg::MMODE_GRP && idx == 3'(i))
                mmode_q[i] <= cab_pkg::cab_mmode_t'(bus.wdata[6:0]);
        end

        // capture beats a software write; pwm reloads duty at low wrap
        always_ff @(posedge CLK_IN)
        begin
            if (!NRST_IN)
                cap_q[i] <= 16'h0000;
            else if (cap_ev[i])
                cap_q[i] <= cnt_q;
            else if (bus.wr && grp == cab_pkg::CAPL_GRP && idx == 3'(i))
                cap_q[i][7:0] <= bus.wdata;
            else if (bus.wr && grp == cab_pkg::CAPH_GRP && idx == 3'(i))
                cap_q[i][15:8] <= bus.wdata;
            else if (m.pwm && tick && cnt_q[7:0] == cab_pkg::LOW_MAX)
                cap_q[i][7:0] <= cap_q[i][15:8];
        end

        always_ff @(posedge CLK_IN)
        begin
            if (!NRST_IN)
                MOD_PIN_OUT[i] <= 1'b1;
            else if (m.pwm)
                MOD_PIN_OUT[i] <= (cnt_q[7:0] >= cap_q[i][7:0]);
            else if (match_ev[i] && m.tog)
                MOD_PIN_OUT[i] <= !MOD_PIN_OUT[i];
        end

        // pin stays released for ordinary port use unless driving
        always_ff @(posedge CLK_IN)
        begin
            if (!NRST_IN)
                MOD_PIN_OE_N_OUT[i] <= 1'b1;
            else
                MOD_PIN_OE_N_OUT[i] <= !(m.pwm || m.tog);
        end
    end

    // only the last channel may reset the system
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            WDT_RESET_OUT <= 1'b0;
        else
            WDT_RESET_OUT <= match_ev[cab_pkg::WDT_MOD] &&
                             mode_q[cab_pkg::MODE_WDT_BIT];
    end

    // ************************************************************
    // interrupt and read-back
    // ************************************************************
    logic [7:0] flags, doc_en, rd_val;
    logic [4:0] eccf;

    for (genvar j = 0; j < cab_pkg::NUM_MOD; j++)
    begin : g_en
        assign eccf[j] = mmode_q[j].eccf;
    end

    assign flags  = {ovf_flag_q, 2'b00, ev_flag_q};
    assign doc_en = {mode_q[cab_pkg::MODE_IRQ_BIT], 2'b00, eccf};

    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            IRQ_OUT <= 1'b0;
        else
            IRQ_OUT <= |(flags & doc_en & ien_q);
    end

    always_comb
    begin
        rd_val = 8'h00;
        case (bus.addr)
            cab_pkg::MODE_OFS: rd_val = mode_q;
            cab_pkg::CTRL_OFS: rd_val = {ovf_flag_q, run_q, 1'b0, ev_flag_q};
            cab_pkg::CNTL_OFS: rd_val = cnt_q[7:0];
            cab_pkg::CNTH_OFS: rd_val = cnt_q[15:8];
            cab_pkg::IST_OFS:  rd_val = flags;
            cab_pkg::IEN_OFS:  rd_val = ien_q;
            default:
            begin
                if (idx_ok && grp == cab_pkg::MMODE_GRP)
                    rd_val = {1'b0, mmode_q[idx]};
                else if (idx_ok && grp == cab_pkg::CAPL_GRP)
                    rd_val = cap_q[idx][7:0];
                else if (idx_ok && grp == cab_pkg::CAPH_GRP)
                    rd_val = cap_q[idx][15:8];
            end
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            RDATA_OUT <= 8'h00;
        else
            RDATA_OUT <= bus.rd ? rd_val : 8'h00;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence s_eci_drop;
        eci_s2_q ##1 !eci_s2_q;
    endsequence

    a_count_step: assert property (
        tick && !cnt_wr |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not advance by one");
    a_stopped_hold: assert property (
        !run_q && !cnt_wr |=> $stable(cnt_q))
        else $error("counter moved while stopped");
    a_ovf_set: assert property (
        cnt_q == cab_pkg::CNT_MAX && tick && !cnt_wr
        |=> ovf_flag_q && cnt_q == cab_pkg::CNT_RST)
        else $error("wrap did not set overflow flag");
    a_ovf_sticky: assert property (
        ovf_flag_q && !wr_ctrl && !wr_iclr |=> ovf_flag_q)
        else $error("overflow flag lost without software");
    a_slow_rate: assert property (
        tick && src == cab_pkg::SRC_SLOW && !SIX_CLK_MODE_IN
        ##1 !SIX_CLK_MODE_IN |-> !tick[*8])
        else $error("slow source ticked too soon");
    a_ext_count: assert property (
        (s_eci_drop ##0 (run_q && src == cab_pkg::SRC_EXT && !idle_stop))
        |-> tick)
        else $error("external falling edge not counted");
    a_t0_count: assert property (
        run_q && src == cab_pkg::SRC_T0 && T0_OVF_IN && !idle_stop |-> tick)
        else $error("timer 0 overflow not counted");
    a_set_wins: assert property (
        ev[0] && wr_ctrl && !bus.wdata[0] |=> ev_flag_q[0])
        else $error("event lost to same-cycle clear");
    a_clear_zero: assert property (
        wr_ctrl && !bus.wdata[1] && !ev[1] && !wr_iclr |=> !ev_flag_q[1])
        else $error("event flag not cleared by zero write");
    a_capture_val: assert property (
        cap_ev[1] |=> cap_q[1] == $past(cnt_q) && ev_flag_q[1])
        else $error("capture missed count or flag");
    a_pin_release: assert property (
        !mmode_q[3].pwm && !mmode_q[3].tog |=> MOD_PIN_OE_N_OUT[3])
        else $error("idle channel still drives its pin");
    a_wdt_pulse: assert property (
        match_ev[4] && mode_q[cab_pkg::MODE_WDT_BIT] |=> WDT_RESET_OUT)
        else $error("watchdog match gave no reset");
    a_irq_level: assert property (
        ovf_flag_q && mode_q[0] && ien_q[7] |=> IRQ_OUT)
        else $error("enabled overflow gave no interrupt");

endmodule : cab_timebase

// >>> tb_top.sv
// self-checking bench for the counter array time base
// assumes cab_pkg, cab_timebase and cab_pin_model are compiled first
`timescale 1ns/10ps
module tb_top;
    logic        clk, nrst, wr, rd, six, idle, t0, ext, irq, wdt;
    logic [5:0]  addr;
    logic [7:0]  wdata, rdata, last_rd;
    logic [4:0]  pin_in, pin_out, oe_n, lvl;
    logic        rd_p1;
    logic [15:0] note, r16;
    logic [15:0] exp_q[$];
    int          error_cnt, check_count, seed_v, dv, wdt_cnt;

    // wire level: the channel wins where it drives, else the model
    assign pin_in = (~oe_n & pin_out) | (oe_n & lvl);

    cab_timebase DUT (.CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .SIX_CLK_MODE_IN(six), .IDLE_IN(idle), .T0_OVF_IN(t0),
        .EXT_COUNT_IN(ext), .MOD_PIN_IN(pin_in), .MOD_PIN_OUT(pin_out),
        .MOD_PIN_OE_N_OUT(oe_n), .IRQ_OUT(irq), .WDT_RESET_OUT(wdt));
    cab_pin_model PM (.CLK_IN(clk), .EXT_OUT(ext), .LVL_OUT(lvl));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // note the expectation; the monitor compares under the mask
    task automatic rd_reg(input logic [5:0] a, input logic [7:0] e,
                          input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge clk);
        rd   <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : rd_reg

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            t0 <= 1'b1;
            @(posedge clk);
            t0 <= 1'b0;
        end
    endtask : tick

    task automatic set_cnt(input logic [15:0] v);
        wr_reg(cab_pkg::CNTL_OFS, v[7:0]);
        wr_reg(cab_pkg::CNTH_OFS, v[15:8]);
    endtask : set_cnt

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask : end_test

    // read data stand only in the cycle after the strobe cycle
    always @(posedge clk)
    begin
        rd_p1 <= rd;
        if (wdt === 1'b1)
            wdt_cnt++;
        if (rd_p1 === 1'b1)
        begin
            last_rd = rdata;
            if (exp_q.size() == 0)
                check(16'h0001, 16'h0000);
            else
            begin
                note = exp_q.pop_front();
                check(16'(rdata & note[15:8]),
                      16'(note[7:0] & note[15:8]));
            end
        end
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        {nrst, wr, rd, six, idle, t0} = 6'h00;
        addr = 6'h00;
        wdata = 8'h00;
        error_cnt = 0;
        check_count = 0;
        seed_v = $urandom(32'h5F7B);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check(16'({pin_out, oe_n, irq, wdt}), 16'h0FFC);
        rd_reg(cab_pkg::MODE_OFS, 8'h00, 8'hFF);
        rd_reg(cab_pkg::CTRL_OFS, 8'h00, 8'hFF);
        rd_reg(cab_pkg::CNTL_OFS, 8'h00, 8'hFF);
        rd_reg(cab_pkg::CNTH_OFS, 8'h00, 8'hFF);
        rd_reg(cab_pkg::IEN_OFS, cab_pkg::IEN_RST, 8'hFF);
        rd_reg(cab_pkg::ICLR_OFS, 8'h00, 8'hFF);
        rd_reg(6'h3F, 8'h00, 8'hFF);
        end_test("reset");
        r16 = 16'($urandom());
        set_cnt(r16);
        rd_reg(cab_pkg::CNTL_OFS, r16[7:0], 8'hFF);
        rd_reg(cab_pkg::CNTH_OFS, r16[15:8], 8'hFF);
        end_test("count access");
        // overflow through timer 0 with the interrupt enabled
        set_cnt(16'hFFFE);
        wr_reg(cab_pkg::MODE_OFS, 8'h05);
        wr_reg(cab_pkg::CTRL_OFS, 8'h40);
        tick(3);
        wr_reg(cab_pkg::CTRL_OFS, 8'h9F);
        tick(2);
        rd_reg(cab_pkg::CNTL_OFS, 8'h01, 8'hFF);
        rd_reg(cab_pkg::CNTH_OFS, 8'h00, 8'hFF);
        rd_reg(cab_pkg::CTRL_OFS, 8'h80, 8'hC0);
        check(16'(irq), 16'h0001);
        wr_reg(cab_pkg::IEN_OFS, 8'h1F);
        settle();
        check(16'(irq), 16'h0000);
        wr_reg(cab_pkg::IEN_OFS, 8'h9F);
        settle();
        check(16'(irq), 16'h0001);
        wr_reg(cab_pkg::ICLR_OFS, 8'h80);
        settle();
        check(16'(irq), 16'h0000);
        rd_reg(cab_pkg::IST_OFS, 8'h00, 8'hFF);
        end_test("overflow");
        // no interrupt enable: timer 0 still counts
        set_cnt(16'hFFFF);
        wr_reg(cab_pkg::MODE_OFS, 8'h04);
        wr_reg(cab_pkg::CTRL_OFS, 8'h40);
        tick(1);
        settle();
        check(16'(irq), 16'h0000);
        rd_reg(cab_pkg::CTRL_OFS, 8'hC0, 8'hC0);
        wr_reg(cab_pkg::CTRL_OFS, 8'h1F);
        rd_reg(cab_pkg::CTRL_OFS, 8'h00, 8'hFF);
        end_test("flag clear");
        // all five channels match the one shared count
        set_cnt(16'h0000);
        for (int n = 0; n < 5; n++)
        begin
            wr_reg(6'h08 + 6'(n),
                   (n == 2) ? 8'h4C : (n == 0) ? 8'h49 : 8'h48);
            wr_reg(6'h10 + 6'(n), 8'h03);
            wr_reg(6'h18 + 6'(n), 8'h00);
        end
        wr_reg(cab_pkg::CTRL_OFS, 8'h40);
        tick(3);
        wr_reg(cab_pkg::CTRL_OFS, 8'h9F);
        rd_reg(cab_pkg::CTRL_OFS, 8'h1F, 8'h1F);
        settle();
        check(16'(oe_n), 16'h001B);
        check(16'(pin_out[2]), 16'h0000);
        check(16'(irq), 16'h0001);
        wr_reg(cab_pkg::CTRL_OFS, 8'h80);
        rd_reg(cab_pkg::CTRL_OFS, 8'h00, 8'h1F);
        end_test("compare");
        // falling then rising edge on channel 1 copies the count
        wr_reg(6'h09, 8'h10);
        set_cnt(16'h1234);
        PM.pin_set(1, 1'b0);
        repeat (6) @(posedge clk);
        rd_reg(6'h11, 8'h34, 8'hFF);
        rd_reg(6'h19, 8'h12, 8'hFF);
        rd_reg(cab_pkg::CTRL_OFS, 8'h02, 8'h02);
        wr_reg(6'h09, 8'h20);
        set_cnt(16'h5678);
        PM.pin_set(1, 1'b1);
        repeat (6) @(posedge clk);
        rd_reg(6'h11, 8'h78, 8'hFF);
        rd_reg(6'h19, 8'h56, 8'hFF);
        end_test("capture");
        set_cnt(16'h0000);
        wr_reg(cab_pkg::MODE_OFS, 8'h06);
        wr_reg(cab_pkg::CTRL_OFS, 8'h40);
        PM.ext_pulses(5);
        repeat (6) @(posedge clk);
        wr_reg(cab_pkg::CTRL_OFS, 8'h9F);
        rd_reg(cab_pkg::CNTL_OFS, 8'h05, 8'hFF);
        end_test("external");
        // idle stops counting only with mode bit 7 set
        set_cnt(16'h0000);
        wr_reg(cab_pkg::MODE_OFS, 8'h84);
        wr_reg(cab_pkg::CTRL_OFS, 8'h40);
        idle <= 1'b1;
        tick(2);
        idle <= 1'b0;
        tick(1);
        wr_reg(cab_pkg::CTRL_OFS, 8'h9F);
        rd_reg(cab_pkg::CNTL_OFS, 8'h01, 8'hFF);
        end_test("idle");
        // match lands in the cycle of a zero write to the flags
        set_cnt(16'h0002);
        wr_reg(cab_pkg::MODE_OFS, 8'h44);
        wr_reg(cab_pkg::CTRL_OFS, 8'h40);
        @(posedge clk);
        t0    <= 1'b1;
        @(posedge clk);
        t0    <= 1'b0;
        addr  <= cab_pkg::CTRL_OFS;
        wdata <= 8'h40;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wr_reg(cab_pkg::CTRL_OFS, 8'h9F);
        rd_reg(cab_pkg::CTRL_OFS, 8'h1D, 8'h1F);
        check(16'(wdt_cnt), 16'h0001);
        end_test("set wins");
        // eight periods of each rate; phase of the divider gives +-1
        for (int m = 0; m < 4; m++)
        begin
            six <= m[1];
            dv = (m == 0) ? 12 : (m == 1) ? 4 : (m == 2) ? 6 : 2;
            set_cnt(16'h0000);
            wr_reg(cab_pkg::MODE_OFS, {6'h00, m[0], 1'b0});
            wr_reg(cab_pkg::CTRL_OFS, 8'h40);
            repeat (dv * 8) @(posedge clk);
            wr_reg(cab_pkg::CTRL_OFS, 8'h9F);
            rd_reg(cab_pkg::CNTL_OFS, 8'h00, 8'h00);
            check(16'(last_rd >= 8'h07 && last_rd <= 8'h09),
                  16'h0001);
        end
        end_test("rates");
        // channel 3 as pwm: pin high while count low >= duty
        wr_reg(6'h0B, 8'h42);
        wr_reg(6'h13, 8'h80);
        wr_reg(6'h1B, 8'h80);
        set_cnt(16'h0010);
        settle();
        check(16'({oe_n, pin_out[3]}), 16'h0026);
        set_cnt(16'h0090);
        settle();
        check(16'(pin_out[3]), 16'h0001);
        end_test("pwm");
        give_verdict();
    end
endmodule : tb_top
